/* hw/sfq_link.sv */
// Serial flash pin front end: framing, mode switching and lane shifting
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: Single-line mode samples instruction, address, write data on data line 0 rising.
// R2: Works with clock idle low or idle high; samples on rising edge.
// R3: Single-line mode returns read data on data line 1 only.
// R4: Single-line instruction takes eight rising edges on data line 0.
// R5: Code 35h enters four-line instruction mode.
// R6: Code F5h leaves four-line instruction mode, independent of quad enable bit.
// R7: Four-line instruction mode takes instruction in two clocks, four bits each.
// R8: Exactly one interface mode is active at a time.
// R9: Reset, pin reset or software reset returns to single-line mode; pin reset is ignored while in four-line mode.
// R10: Four-line mode uses all four pins as bidirectional data lines.
// R11: Double-edge reads take address and drive data on both edges.
// R12: Dual and quad output and input/output transfers move two or four bits.
// R13: Page program accepts up to 256 bytes wrapping within one page.
// R14: Erase addresses align to 4K, 32K or 64K boundaries; chip erase whole.
// R15: Erased locations read as all ones.
// R16: Wrapped reads stay inside an aligned 8, 16, 32 or 64 byte window.
// R17: Four 256-byte security areas; locked areas refuse program and erase.
// R18: A 128-bit unique identifier is readable.
// R19: Select high deselects, floats outputs and ignores data.
// R20: Host must raise select after power-up before first instruction.
// R21: Data line 3 is pause input, or reset input when selected.
// R22: Select low frames an instruction; select high ends it and resets decoder.
module sfq_link
   import sfq_pkg::*;
#(
   parameter int           DUMMY_CYC = 8,
   // Arbitrary value
   parameter logic [127:0] UNIQUE_ID = 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0
) (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        ce,
   input  wire logic        sckPin,
   input  wire logic        csPin_b,
   input  wire logic [3:0]  ioIn,
   output logic      [3:0]  ioOut,
   output logic      [3:0]  ioOeB,
   input  wire logic        pauseOrResetPinSelect,
   input  wire logic        wrapOn,
   input  wire logic [1:0]  wrapLen,
   input  wire logic [3:0]  secLock,
   output logic             rxValid,
   output logic      [7:0]  rxByte,
   output logic      [7:0]  rxCol,
   input  wire logic        rxReady,
   input  wire logic        txValid,
   input  wire logic [7:0]  txByte,
   output logic             txReady,
   output logic      [23:0] rdAddr,
   output logic             cmdStrobe,
   output logic      [7:0]  cmdCode,
   output logic      [23:0] cmdAddr,
   output logic             cmdRefused,
   output logic             fourLineMode,
   output logic             rxOverrun
);

   if (DUMMY_CYC < 1 || DUMMY_CYC > 63) begin : g_bad_dummy
      $error("DUMMY_CYC must lie in 1..63");
   end

   typedef struct packed {
      logic        sck1, sck2, sckOld, cs1, cs2;
      logic [3:0]  io1, io2;
      logic        armed, fl, rstArm;
      sfq_phase_e  phase;
      sfq_cmd_s    cmd;
      logic [7:0]  opc, sh, txSh, txHold, col, cmdCode;
      logic [5:0]  cnt;
      logic [3:0]  txCnt, uidIdx, frmRise, ioOut, ioOeB;
      logic        txRdy, rxV, overrun, cmdStrobe, cmdRefused;
      logic [1:0]  n;
      logic [15:0] b0, b1;
      logic [23:0] addr, rdAddr, cmdAddr;
   } sfq_st_s;

   sfq_st_s    st;
   sfq_st_s    next_st;
   logic       opDone;
   logic [7:0] opVal;

   // Instruction decode to lane widths and phases
   function automatic sfq_cmd_s dec(input logic [7:0] op, input logic q);
      sfq_cmd_s c;
      c = '0;
      c.aLanes = q ? LANE4 : LANE1;
      c.dLanes = c.aLanes;
      case (op)
         OP_READ: begin
            c.hasAddr = 1'b1;
            c.rd = 1'b1;
         end
         OP_FREAD, OP_UID, OP_SREAD: begin
            c.hasAddr = 1'b1;
            c.rd = 1'b1;
            c.dummy = 1'b1;
         end
         OP_DOUT, OP_DIO, OP_QOUT, OP_QIO: begin
            c.hasAddr = 1'b1;
            c.rd = 1'b1;
            c.dummy = 1'b1;
            c.dLanes = (q || op == OP_QOUT || op == OP_QIO) ? LANE4 : LANE2;
            if (op == OP_DIO || op == OP_QIO) c.aLanes = c.dLanes; // R12
         end
         OP_DTR1, OP_DTR2, OP_DTR4: begin
            c.hasAddr = 1'b1;
            c.rd = 1'b1;
            c.dummy = 1'b1;
            c.dtr = 1'b1; // R11
            if (!q && op == OP_DTR2) c.dLanes = LANE2;
            if (op == OP_DTR4) c.dLanes = LANE4;
            c.aLanes = c.dLanes;
         end
         OP_PP, OP_SPROG, OP_PPQ, OP_PPQ2: begin
            c.hasAddr = 1'b1;
            c.wr = 1'b1;
            if (op == OP_PPQ || op == OP_PPQ2) c.dLanes = LANE4; // R12
         end
         OP_SER, OP_SER2, OP_BE32, OP_BE64, OP_SERASE: c.hasAddr = 1'b1;
         default: c = c;
      endcase
      return c;
   endfunction

   // Shift sampled lanes into a word, most significant first
   function automatic logic [23:0] shIn(input logic [23:0] w,
                                        input logic [3:0] d,
                                        input logic [2:0] ln);
      case (ln)
         LANE4:   return {w[19:0], d};
         LANE2:   return {w[21:0], d[1:0]};
         default: return {w[22:0], d[0]}; // R1
      endcase
   endfunction

   // Erase base address on its uniform boundary
   function automatic logic [23:0] alignFor(input logic [7:0] op,
                                            input logic [23:0] a);
      case (op)
         OP_SER, OP_SER2: return a & ~((24'h1 << SEC4K_LSB) - 24'h1); // R14
         OP_BE32: return a & ~((24'h1 << BLK32_LSB) - 24'h1); // R14
         OP_BE64: return a & ~((24'h1 << BLK64_LSB) - 24'h1); // R14
         default: return a;
      endcase
   endfunction

   // Next read address, optionally wrapped in its window
   function automatic logic [23:0] nextRd(input logic [23:0] a,
                                          input logic on,
                                          input logic [1:0] len);
      logic [23:0] m;
      m = {17'h0, WRAP_MIN << len} - 24'h1;
      return on ? ((a & ~m) | ((a + 24'h1) & m)) : a + 24'h1; // R16
   endfunction

   // Next state of the whole front end
   always_comb begin
      logic       rise, fall, act, drv, paused, pinRst, quadUse;
      logic [2:0] ln;
      logic [7:0] nb;
      logic [23:0] w;
      sfq_cmd_s   c;
      rise = 1'b0;
      fall = 1'b0;
      act = 1'b0;
      drv = 1'b0;
      paused = 1'b0;
      pinRst = 1'b0;
      quadUse = 1'b0;
      ln = LANE1;
      nb = ERASED;
      w = '0;
      c = '0;
      opDone = 1'b0;
      opVal = '0;
      next_st = st;
      if (ce) begin
         next_st.sck1 = sckPin;
         next_st.sck2 = st.sck1;
         next_st.sckOld = st.sck2;
         next_st.cs1 = csPin_b;
         next_st.cs2 = st.cs1;
         next_st.io1 = ioIn;
         next_st.io2 = st.io1;
         rise = st.sck2 & ~st.sckOld; // R2
         fall = ~st.sck2 & st.sckOld;
         next_st.cmdStrobe = 1'b0;
         next_st.cmdRefused = 1'b0;
         // Drain side of the receive buffer
         if (st.rxV && rxReady) begin
            next_st.b0 = st.b1;
            next_st.n = st.n - 2'h1;
         end
         // Read data holding register
         if (st.txRdy && txValid) begin
            next_st.txHold = txByte;
            next_st.txRdy = 1'b0;
         end
         quadUse = st.fl | (st.phase == PH_ADDR && st.cmd.aLanes == LANE4)
            | (st.phase >= PH_DUMMY && st.cmd.dLanes == LANE4);
         paused = ~quadUse & ~st.io2[3] & ~pauseOrResetPinSelect; // R21
         pinRst = ~quadUse & ~st.io2[3] & pauseOrResetPinSelect; // R21
         if (st.phase == PH_OPC)
            ln = st.fl ? LANE4 : LANE1; // R7
         else if (st.phase == PH_ADDR)
            ln = st.cmd.aLanes;
         else
            ln = st.cmd.dLanes;
         act = rise | (fall & st.cmd.dtr & (st.phase == PH_ADDR)
                       & (st.cnt != ADDR_CNT)); // R11
         drv = fall | (rise & st.cmd.dtr); // R11
         w = shIn({16'h0, st.sh}, st.io2, ln);
         if (st.cs2) begin
            next_st.phase = PH_IDLE; // R22
            next_st.ioOeB = OE_OFF; // R19
            next_st.armed = 1'b1;
            next_st.frmRise = '0;
         end else if (pinRst) begin
            next_st.fl = 1'b0; // R9
            next_st.armed = 1'b0;
            next_st.phase = PH_IDLE;
            next_st.ioOeB = OE_OFF;
         end else if (st.phase == PH_IDLE) begin
            if (st.armed) begin // R20
               next_st.phase = PH_OPC;
               next_st.cnt = OPC_BITS;
            end
         end else if (!paused) begin
            if (rise && st.frmRise != 4'hf)
               next_st.frmRise = st.frmRise + 4'h1;
            case (st.phase)
               PH_OPC: if (rise) begin // R4 R7
                  next_st.sh = w[7:0];
                  next_st.cnt = st.cnt - {3'h0, ln};
                  if (st.cnt == {3'h0, ln}) begin
                     opDone = 1'b1;
                     opVal = w[7:0];
                     c = dec(w[7:0], st.fl);
                     next_st.cmd = c;
                     next_st.opc = w[7:0];
                     next_st.cmdCode = w[7:0];
                     next_st.rstArm = (w[7:0] == OP_RST_EN);
                     if (w[7:0] == OP_FL_ON) next_st.fl = 1'b1; // R5 R8
                     if (w[7:0] == OP_FL_OFF) next_st.fl = 1'b0; // R6 R8
                     if (w[7:0] == OP_RST && st.rstArm)
                        next_st.fl = 1'b0; // R9
                     if (c.hasAddr) begin
                        next_st.phase = PH_ADDR;
                        next_st.cnt = ADDR_CNT;
                     end else begin
                        next_st.phase = PH_SKIP;
                        next_st.cmdStrobe = 1'b1;
                        next_st.cmdAddr = '0; // R14
                     end
                  end
               end
               PH_ADDR: if (act) begin
                  w = shIn(st.addr, st.io2, ln);
                  next_st.addr = w;
                  next_st.cnt = st.cnt - {3'h0, ln};
                  if (st.cnt == {3'h0, ln}) begin
                     next_st.cmdStrobe = 1'b1;
                     next_st.cmdAddr = alignFor(st.opc, w); // R14
                     next_st.rdAddr = w;
                     next_st.col = w[7:0];
                     next_st.txRdy = 1'b1;
                     next_st.txCnt = '0;
                     next_st.uidIdx = '0;
                     next_st.cnt = DUMMY_CYC[5:0];
                     next_st.cmdRefused = (st.opc == OP_SPROG
                        || st.opc == OP_SERASE)
                        && secLock[w[AREA_LSB +: 2]]; // R17
                     if (st.cmd.dummy)
                        next_st.phase = PH_DUMMY;
                     else if (st.cmd.rd)
                        next_st.phase = PH_DOUT;
                     else if (st.cmd.wr && !next_st.cmdRefused) begin
                        next_st.phase = PH_DIN;
                        next_st.cnt = BYTE_CNT;
                     end else
                        next_st.phase = PH_SKIP;
                  end
               end
               PH_DUMMY: if (rise) begin
                  next_st.cnt = st.cnt - 6'h1;
                  if (st.cnt == 6'h1)
                     next_st.phase = st.cmd.rd ? PH_DOUT : PH_SKIP;
               end
               PH_DIN: if (rise) begin // R12
                  next_st.sh = w[7:0];
                  next_st.cnt = st.cnt - {3'h0, ln};
                  if (st.cnt == {3'h0, ln}) begin
                     next_st.cnt = BYTE_CNT;
                     next_st.col = st.col + 8'h01; // R13
                     if (next_st.n == 2'h2)
                        next_st.overrun = 1'b1;
                     else begin
                        if (next_st.n == 2'h0)
                           next_st.b0 = {st.col, w[7:0]};
                        else
                           next_st.b1 = {st.col, w[7:0]};
                        next_st.n = next_st.n + 2'h1;
                     end
                  end
               end
               PH_DOUT: if (drv) begin
                  if (st.txCnt != 4'h0)
                     nb = st.txSh;
                  else if (st.opc == OP_UID) begin
                     nb = UNIQUE_ID[{st.uidIdx, 3'h0} +: 8]; // R18
                     next_st.uidIdx = st.uidIdx + 4'h1;
                  end else if (!st.txRdy) begin
                     nb = st.txHold;
                     next_st.txRdy = 1'b1;
                     next_st.rdAddr = nextRd(st.rdAddr, wrapOn, wrapLen);
                  end else
                     nb = ERASED; // R15
                  case (ln)
                     LANE4: begin
                        next_st.ioOut = nb[7:4];
                        next_st.ioOeB = OE_ALL; // R10
                     end
                     LANE2: begin
                        next_st.ioOut = {2'h0, nb[7:6]};
                        next_st.ioOeB = OE_D01;
                     end
                     default: begin
                        next_st.ioOut = {2'h0, nb[7], 1'h0};
                        next_st.ioOeB = OE_D1; // R3
                     end
                  endcase
                  next_st.txSh = nb << ln;
                  next_st.txCnt = (st.txCnt == 4'h0 ? TX_BITS : st.txCnt)
                     - {1'h0, ln};
               end
               default: next_st.phase = st.phase;
            endcase
         end
         next_st.rxV = (next_st.n != 2'h0);
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0; // R9
         st.cs1 <= 1'b1;
         st.cs2 <= 1'b1;
         st.ioOeB <= OE_OFF;
         st.txRdy <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register
   assign ioOut = st.ioOut;
   assign ioOeB = st.ioOeB;
   assign rxValid = st.rxV;
   assign rxByte = st.b0[7:0];
   assign rxCol = st.b0[15:8];
   assign txReady = st.txRdy;
   assign rdAddr = st.rdAddr;
   assign cmdStrobe = st.cmdStrobe;
   assign cmdCode = st.cmdCode;
   assign cmdAddr = st.cmdAddr;
   assign cmdRefused = st.cmdRefused;
   assign fourLineMode = st.fl;
   assign rxOverrun = st.overrun;

   // Checks on the pin behaviour
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   chk_desel_float: assert property (ce && st.cs2 |=> ioOeB == OE_OFF) // R19
      else $error("outputs driven while deselected");
   chk_desel_idle: assert property (ce && st.cs2 |=> st.phase == PH_IDLE) // R22
      else $error("decoder not reset at frame end");
   chk_fl_enter: assert property (opDone && opVal == OP_FL_ON |=> fourLineMode) // R5
      else $error("four-line mode not entered");
   chk_fl_leave: assert property (opDone && opVal == OP_FL_OFF |=> !fourLineMode) // R6
      else $error("four-line mode not left");
   chk_soft_reset: assert property (opDone && opVal == OP_RST && st.rstArm
      |=> !fourLineMode) // R9
      else $error("software reset kept four-line mode");
   chk_single_opc: assert property (opDone && !st.fl |-> st.frmRise == 4'h7) // R4
      else $error("single-line instruction not eight clocks");
   chk_quad_opc: assert property (opDone && st.fl |-> st.frmRise == 4'h1) // R7
      else $error("four-line instruction not two clocks");
   chk_single_out: assert property (!fourLineMode && st.cmd.dLanes == LANE1
      && ioOeB != OE_OFF |-> ioOeB == OE_D1) // R3
      else $error("single-line read drives wrong pins");
   chk_fl_lanes: assert property (fourLineMode && st.phase == PH_DOUT
      && ioOeB != OE_OFF |-> ioOeB == OE_ALL) // R10
      else $error("four-line read not on all lines");
   chk_wrap_window: assert property ($past(wrapOn) && $changed(rdAddr)
      && $past(st.phase) == PH_DOUT
      |-> rdAddr[23:6] == $past(rdAddr[23:6])) // R16
      else $error("wrapped read left its window");
   chk_pin_reset: assert property (ce && !st.cs2 && pauseOrResetPinSelect
      && !st.io2[3] && st.phase == PH_OPC && !st.fl
      |=> st.phase == PH_IDLE && !st.armed) // R21
      else $error("pin reset ignored");

   cov_enter_fl: cover property (opDone && opVal == OP_FL_ON);
   cov_quad_read: cover property (st.phase == PH_DOUT && ioOeB == OE_ALL);
   cov_rx_full: cover property (st.n == 2'h2 && !rxReady);
   cov_dtr_read: cover property (st.cmd.dtr && st.phase == PH_DOUT);

endmodule // sfq_link
`default_nettype wire

/* hw/sfq_pkg.sv */
// Opcodes, lane widths, field positions and types of the flash front end
package sfq_pkg;
   // Instruction codes
   localparam logic [7:0] OP_FL_ON   = 8'h35;
   localparam logic [7:0] OP_FL_OFF  = 8'hf5;
   localparam logic [7:0] OP_RST_EN  = 8'h66;
   localparam logic [7:0] OP_RST     = 8'h99;
   localparam logic [7:0] OP_READ    = 8'h03;
   localparam logic [7:0] OP_FREAD   = 8'h0b;
   localparam logic [7:0] OP_DOUT    = 8'h3b;
   localparam logic [7:0] OP_DIO     = 8'hbb;
   localparam logic [7:0] OP_QOUT    = 8'h6b;
   localparam logic [7:0] OP_QIO     = 8'heb;
   localparam logic [7:0] OP_DTR1    = 8'h0d;
   localparam logic [7:0] OP_DTR2    = 8'hbd;
   localparam logic [7:0] OP_DTR4    = 8'hed;
   localparam logic [7:0] OP_PP      = 8'h02;
   localparam logic [7:0] OP_PPQ     = 8'h32;
   localparam logic [7:0] OP_PPQ2    = 8'h38;
   localparam logic [7:0] OP_SER     = 8'h20;
   localparam logic [7:0] OP_SER2    = 8'hd7;
   localparam logic [7:0] OP_BE32    = 8'h52;
   localparam logic [7:0] OP_BE64    = 8'hd8;
   localparam logic [7:0] OP_UID     = 8'h4b;
   localparam logic [7:0] OP_SREAD   = 8'h68;
   localparam logic [7:0] OP_SPROG   = 8'h62;
   localparam logic [7:0] OP_SERASE  = 8'h64;
   // Lane widths
   localparam logic [2:0] LANE1 = 3'h1;
   localparam logic [2:0] LANE2 = 3'h2;
   localparam logic [2:0] LANE4 = 3'h4;
   // Phase lengths in bits
   localparam logic [5:0] OPC_BITS = 6'h08;
   localparam logic [5:0] ADDR_CNT = 6'h18;
   localparam logic [5:0] BYTE_CNT = 6'h08;
   localparam logic [3:0] TX_BITS  = 4'h8;
   // Field positions and values
   localparam int          SEC4K_LSB = 12;
   localparam int          BLK32_LSB = 15;
   localparam int          BLK64_LSB = 16;
   localparam int          AREA_LSB  = 8;
   localparam logic [7:0]  ERASED    = 8'hff;
   localparam logic [6:0]  WRAP_MIN  = 7'h08;
   // Output enables, low means driven
   localparam logic [3:0]  OE_OFF = 4'hf;
   localparam logic [3:0]  OE_D1  = 4'hd;
   localparam logic [3:0]  OE_D01 = 4'hc;
   localparam logic [3:0]  OE_ALL = 4'h0;

   typedef enum logic [2:0] {
      PH_IDLE  = 3'b000,
      PH_OPC   = 3'b001,
      PH_ADDR  = 3'b010,
      PH_DUMMY = 3'b011,
      PH_DIN   = 3'b100,
      PH_DOUT  = 3'b101,
      PH_SKIP  = 3'b110
   } sfq_phase_e;

   typedef struct packed {
      logic       hasAddr;
      logic [2:0] aLanes;
      logic       dummy;
      logic [2:0] dLanes;
      logic       rd;
      logic       wr;
      logic       dtr;
   } sfq_cmd_s;
endpackage

/* tb/sfq_host_model.sv */
// Host flash controller model driving clock, select and data lines
`timescale 1ns/1ps
`default_nettype none
module sfq_host_model (
   input  wire logic       clk,
   output logic            sck,
   output logic            csB,
   output logic [3:0]      io,
   output logic [3:0]      hostOeB,
   input  wire logic [3:0] pin
);
   logic cpol;

   // Idle pins, select high from the start
   initial begin
      cpol = 1'b0;
      sck = 1'b0;
      csB = 1'b1;
      io = 4'h0;
      hostOeB = 4'hf;
   end

   // Half link period of 80 ns
   task automatic half();
      repeat (8) @(negedge clk);
   endtask

   // Select falls only after it has stood high
   task automatic open_frame(input logic pol);
      cpol = pol;
      sck = pol;
      half();
      csB = 1'b0;
      half();
   endtask

   // Data changes after sck falls, MSB first, ln bits per rise
   task automatic send(input logic [31:0] d, input int n, input int ln);
      for (int i = n - ln; i >= 0; i -= ln) begin
         sck = 1'b0;
         io = 4'((d >> i) & ((1 << ln) - 1));
         hostOeB = 4'(4'hf << ln);
         half();
         sck = 1'b1;
         half();
      end
      hostOeB = 4'hf;
   endtask

   // Samples device lanes on each rising edge
   task automatic recv(output logic [7:0] d, input int ln);
      for (int i = 0; i < 8; i += ln) begin
         sck = 1'b0;
         half();
         sck = 1'b1;
         d = (ln == 4) ? {d[3:0], pin}
           : (ln == 2) ? {d[5:0], pin[1:0]} : {d[6:0], pin[1]};
         half();
      end
   endtask

   // Clock back to idle, then select high ends the frame
   task automatic close_frame();
      sck = cpol;
      half();
      csB = 1'b1;
      half();
      half();
   endtask
endmodule // sfq_host_model
`default_nettype wire

/* tb/sfq_link_tb.sv */
// Self-checking bench of the flash pin front end
`timescale 1ns/1ps
`default_nettype none
module sfq_link_tb;
   import sfq_pkg::*;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        rxReady = 1'b0;
   logic        txValid = 1'b0;
   logic        txOn = 1'b1;
   logic        pinSel = 1'b0;
   logic [7:0]  rdOp = OP_READ;
   logic        wrapOn = 1'b0;
   logic [1:0]  wrapLen = 2'h0;
   logic [3:0]  secLock = 4'h0;
   logic [7:0]  txByte = 8'h00;
   logic        sck, csB, rxValid, txReady, cmdStrobe, cmdRefused;
   logic        fourLineMode, rxOverrun, lastRef;
   logic [3:0]  hIo, hOe, ioOut, ioOeB, ioWire;
   logic [7:0]  rxByte, rxCol, cmdCode;
   logic [23:0] rdAddr, cmdAddr;
   int          miscompares = 0;
   int          comparisons = 0;
   int          strobes = 0;

   always #5 clk = ~clk;

   // Device drive wins; released hold/protect lines pull up
   assign ioWire = (~ioOeB & ioOut) | (ioOeB & ~hOe & hIo)
                 | (ioOeB & hOe & {2'b11, ~hIo[1:0]});

   sfq_host_model i_sfq_host_model (.clk(clk), .sck(sck), .csB(csB),
      .io(hIo), .hostOeB(hOe), .pin(ioWire));

   sfq_link #(.DUMMY_CYC(8)) i_sfq_link (.clk(clk), .rst_b(rst_b), .ce(1'b1),
      .sckPin(sck), .csPin_b(csB), .ioIn(ioWire), .ioOut(ioOut),
      .ioOeB(ioOeB), .pauseOrResetPinSelect(pinSel), .wrapOn(wrapOn),
      .wrapLen(wrapLen),
      .secLock(secLock), .rxValid(rxValid), .rxByte(rxByte), .rxCol(rxCol),
      .rxReady(rxReady), .txValid(txValid), .txByte(txByte),
      .txReady(txReady), .rdAddr(rdAddr), .cmdStrobe(cmdStrobe),
      .cmdCode(cmdCode), .cmdAddr(cmdAddr), .cmdRefused(cmdRefused),
      .fourLineMode(fourLineMode), .rxOverrun(rxOverrun));

   function automatic logic [7:0] mem_byte(input logic [23:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3c;
   endfunction

   // Address of byte i of a burst, wrapped inside its window
   function automatic logic [23:0] burst_addr(input logic [23:0] a, input int i);
      logic [23:0] m;
      m = wrapOn ? (24'h8 << wrapLen) - 24'h1 : 24'hffffff;
      return (a & ~m) | ((a + 24'(i)) & m);
   endfunction

   // Read source keyed by requested address
   always @(negedge clk) begin
      txValid <= txOn;
      txByte <= mem_byte(rdAddr);
   end

   // Count decoded instructions and keep refusal flag
   always @(negedge clk) begin
      if (cmdStrobe === 1'b1) begin
         strobes++;
         lastRef = cmdRefused;
      end
   end

   task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic complete_run();
      if (miscompares == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // One whole frame: instruction, optional address
   task automatic frame(input logic [7:0] op, input int ln, input logic [23:0] a,
                        input logic hasA);
      i_sfq_host_model.open_frame(1'b0);
      i_sfq_host_model.send(32'(op), 8, ln);
      if (hasA) begin
         i_sfq_host_model.send(32'(a), 24, ln);
      end
      i_sfq_host_model.close_frame();
   endtask

   // Read burst of n bytes with expected data per address
   task automatic do_read(input logic pol, input int ln, input logic [23:0] a,
                          input int n);
      logic [7:0] d;
      i_sfq_host_model.open_frame(pol);
      i_sfq_host_model.send(32'(rdOp), 8, ln == 2 ? 1 : ln);
      i_sfq_host_model.send(32'(a), 24, ln);
      // Eight dummy clocks for fast reads
      if (rdOp != OP_READ) begin
         i_sfq_host_model.send(32'h0, 8 * ln, ln);
      end
      for (int i = 0; i < n; i++) begin
         i_sfq_host_model.recv(d, ln);
         check_val(24'(d), txOn ? 24'(mem_byte(burst_addr(a, i))) : 24'(ERASED));
      end
      i_sfq_host_model.close_frame();
      check_val(cmdAddr, a);
      check_val(24'(ioOeB), 24'(OE_OFF));
   endtask

   // Hang guard
   initial begin
      #900us;
      miscompares++;
      complete_run();
   end

   initial begin
      logic [7:0]  eOps [4];
      int          eLsb [4];
      logic [23:0] a;
      int          s;
      eOps = '{OP_SER, OP_SER2, OP_BE32, OP_BE64};
      eLsb = '{SEC4K_LSB, SEC4K_LSB, BLK32_LSB, BLK64_LSB};
      void'($urandom(32'h9500dbb6));
      repeat (10) @(posedge clk);
      @(negedge clk) rst_b = 1'b1;
      repeat (4) @(negedge clk);
      check_val(24'(ioOeB), 24'(OE_OFF));
      check_val(24'(fourLineMode), 24'h0);
      // Single-line reads in both clock modes, then erased and wrapped
      do_read(1'b0, 1, 24'($urandom), 2);
      do_read(1'b1, 1, 24'($urandom), 2);
      txOn = 1'b0;
      do_read(1'b0, 1, 24'($urandom), 1);
      txOn = 1'b1;
      wrapOn = 1'b1;
      wrapLen = 2'($urandom);
      do_read(1'b0, 1, {18'($urandom), 6'h3e}, 3);
      wrapOn = 1'b0;
      // Dual input/output read with dummy clocks
      rdOp = OP_DIO;
      do_read(1'b0, 2, 24'($urandom), 2);
      rdOp = OP_READ;
      // Four-line mode in and out, then software reset back
      frame(OP_FL_ON, 1, 24'h0, 1'b0);
      check_val(24'(fourLineMode), 24'h1);
      do_read(1'b0, 4, 24'($urandom), 2);
      frame(OP_FL_OFF, 4, 24'h0, 1'b0);
      check_val(24'(fourLineMode), 24'h0);
      frame(OP_FL_ON, 1, 24'h0, 1'b0);
      frame(OP_RST_EN, 4, 24'h0, 1'b0);
      frame(OP_RST, 4, 24'h0, 1'b0);
      check_val(24'(fourLineMode), 24'h0);
      // Erase addresses aligned per granularity
      for (int i = 0; i < 4; i++) begin
         a = 24'($urandom);
         frame(eOps[i], 1, a, 1'b1);
         check_val(24'(cmdCode), 24'(eOps[i]));
         check_val(cmdAddr, (a >> eLsb[i]) << eLsb[i]);
      end
      // Clock toggling while deselected is ignored
      s = strobes;
      i_sfq_host_model.send(32'hffff, 16, 1);
      i_sfq_host_model.close_frame();
      check_val(24'(strobes - s), 24'h0);
      // Line 3 low pauses, or aborts the frame when reset is selected
      for (int p = 0; p < 2; p++) begin
         pinSel = 1'(p);
         i_sfq_host_model.open_frame(1'b0);
         i_sfq_host_model.send(32'h0, 32, 4);
         i_sfq_host_model.close_frame();
         check_val(24'(strobes - s), 24'h0);
      end
      pinSel = 1'b0;
      // Locked security area refuses programming
      secLock = 4'h4;
      frame(OP_SPROG, 1, {14'($urandom), 2'h2, 8'($urandom)}, 1'b1);
      check_val(24'(lastRef), 24'h1);
      // Program three bytes into a stalled two-entry buffer
      a = 24'($urandom);
      i_sfq_host_model.open_frame(1'b0);
      i_sfq_host_model.send(32'(OP_PP), 8, 1);
      i_sfq_host_model.send(32'(a), 24, 1);
      i_sfq_host_model.send(32'h00a55a3c, 24, 1);
      i_sfq_host_model.close_frame();
      check_val(24'(rxOverrun), 24'h1);
      for (int i = 0; i < 2; i++) begin
         check_val(24'(rxValid), 24'h1);
         check_val(24'(rxByte), i == 0 ? 24'ha5 : 24'h5a);
         check_val(24'(rxCol), 24'(8'(a[7:0] + 8'(i))));
         @(negedge clk) rxReady = 1'b1;
         @(negedge clk) rxReady = 1'b0;
      end
      check_val(24'(rxValid), 24'h0);
      complete_run();
   end
endmodule // sfq_link_tb
`default_nettype wire
